// ---- verilog/tdc_pkg.sv ----
// Constants and types of the result readout bank.
// Assumes one 250 MHz system clock; all pins synchronous to it.
package tdc_pkg;
  localparam int CLK_PS = 4000;
  localparam logic [2:0] ADR_RES_LAST = 3'h3;
  localparam logic [2:0] ADR_STAT = 3'h4;
  localparam logic [2:0] ADR_ECHO = 3'h5;
  localparam logic [4:0] OPC_READ = 5'h16;
  localparam logic [3:0] OPC_BITS = 4'h8;
  localparam int STAT_PTR_LSB = 0;
  localparam int STAT_HIT1_LSB = 3;
  localparam int STAT_HIT2_LSB = 6;
  localparam int STAT_TMO_BIT = 9;
  localparam int STAT_PRE_BIT = 10;
  localparam int STAT_OPEN_BIT = 11;
  localparam int STAT_SHORT_BIT = 12;
  localparam logic [2:0] PTR_RST = 3'h0;
  localparam logic [2:0] NUM_SLOTS = 3'h4;
  localparam logic [2:0] MAX_HITS = 3'h4;
  localparam logic [31:0] SLOT_RST = 32'h0;
  localparam logic [31:0] ERR_VAL = 32'hffffffff;
  localparam int TIMEOUT_NS = 1800;
  localparam logic [19:0] TIMEOUT_CYC = 20'(TIMEOUT_NS * 1000 / CLK_PS);
  localparam int VALID_UNCAL_NS = 560;
  localparam int VALID_UNCAL_CYC = VALID_UNCAL_NS * 1000 / CLK_PS;
  localparam int VALID_CAL_NS = 4600;
  localparam int VALID_CAL_CYC = VALID_CAL_NS * 1000 / CLK_PS;
  localparam int STAMP_W = 20;
  localparam int PRE_W = 14;
  localparam int FRAC_W = 16;
  localparam int DIV_NUM_W = 36;
  localparam int DIV_DEN_W = 20;
  localparam int DIV_CNT_W = 6;
  localparam logic [3:0] SEL_START = 4'h0;
  localparam logic [3:0] SEL_CH1_FIRST = 4'h1;
  localparam logic [3:0] SEL_CH1_LAST = 4'h4;
  localparam logic [3:0] SEL_NOP = 4'h5;
  localparam logic [3:0] SEL_CAL1 = 4'h6;
  localparam logic [3:0] SEL_CAL2 = 4'h7;
  localparam logic [3:0] SEL_CH2_FIRST = 4'h9;
  localparam logic [3:0] SEL_CH2_LAST = 4'hc;
  typedef enum logic [2:0] {
    ST_ARMED = 3'b000,
    ST_RUN = 3'b001,
    ST_CSYNC = 3'b010,
    ST_CAL = 3'b011,
    ST_DONE = 3'b100
  } meas_state_t;
endpackage : tdc_pkg

// ---- verilog/div_if.sv ----
// Request and answer lines between the bank and its divider.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none
interface div_if;
  import tdc_pkg::*;
  logic start;
  logic [DIV_NUM_W-1:0] num;
  logic [DIV_DEN_W-1:0] den;
  logic done;
  logic [DIV_NUM_W-1:0] quo;
  modport req (output start, output num, output den, input done, input quo);
  modport unit (input start, input num, input den, output done, output quo);
endinterface : div_if
`default_nettype wire

// ---- verilog/div_unit.sv ----
// Restoring serial divider, one quotient bit per clock.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
`default_nettype none
module div_unit (
  input wire logic i_clk,
  input wire logic i_rst,
  div_if.unit bus
);
  import tdc_pkg::*;
  logic [DIV_NUM_W-1:0] q_q;
  logic [DIV_DEN_W:0] rem_q;
  logic [DIV_DEN_W-1:0] den_q;
  logic [DIV_CNT_W-1:0] cnt_q;
  logic busy_q;
  logic done_q;
  logic [DIV_DEN_W:0] shf;
  logic [DIV_DEN_W:0] dif;

  always_comb begin
    shf = {rem_q[DIV_DEN_W-1:0], q_q[DIV_NUM_W-1]};
    dif = shf - {1'b0, den_q};
  end

  // Zero divisor sets the top 20 quotient bits to ones, which reads as overflow
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q <= '0;
      rem_q <= '0;
      q_q <= '0;
      den_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (bus.start && !busy_q) begin
        q_q <= bus.num;
        den_q <= bus.den;
        rem_q <= '0;
        cnt_q <= DIV_CNT_W'(DIV_NUM_W);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        rem_q <= dif[DIV_DEN_W] ? shf : dif;
        q_q <= {q_q[DIV_NUM_W-2:0], ~dif[DIV_DEN_W]};
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == DIV_CNT_W'(1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign bus.done = done_q;
  assign bus.quo = q_q;

  sequence s_accept;
    bus.start && !busy_q;
  endsequence
  property p_div_time;
    @(posedge i_clk) disable iff (i_rst) s_accept |=> !done_q ##36 done_q;
  endproperty
  a_div_time: assert property (p_div_time) else $error("divider latency wrong");
endmodule : div_unit
`default_nettype wire

// ---- verilog/tdc_readout.sv ----
// Result and status readout bank of the time converter, with hit capture.
// Assumes pins synchronous to I_CLK_SYS; SPI mode 1 from the host.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Address 5 returns the top byte of configuration word 1
// - Status word at address 4 is 16 bits, bits 15 to 13 unused
// - Status bits 2 to 0 hold the next free slot index
// - Status bits 5-3 and 8-6 count stop hits of channels 1 and 2
// - Status bit 9 set when the fine measurement times out
// - Status bit 10 set when the 14-bit long-range precounter overflows
// - Status bits 11 and 12 flag open and shorted temperature sensor
// - Only fine range yields negative results; long range is unsigned
// - Raw results only in fine range; long range always calibrated
// - Fine calibrated interval above two calibration periods writes all ones
// - Calibrated results are signed 16.16 fixed point, one slot each
// - Calibrated results in internal reference periods; reference divided by 1, 2 or 4
// - Results shift out most significant bit first
// - Raw result is 16-bit signed count in upper half, lower half zero
// - Fine interval measured with a 20-bit counter from the start
// - Calibration measures one and two reference periods and keeps both
// - Each stop channel captures up to four hits
// - Fine measurement ends by timeout at about 1.8 us
// - Result valid within 560 ns raw, 4.6 us calibrated
// - Per-input invert bits and per-stop both-edge bits select edges
// - Each start and stop input gated by an active-high enable
// - Each of the first four results advances the next free slot pointer by one
module tdc_readout (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_INIT,
  input wire logic I_REF_CLK,
  input wire logic I_START,
  input wire logic I_STOP1,
  input wire logic I_STOP2,
  input wire logic I_EN_START,
  input wire logic I_EN_STOP1,
  input wire logic I_EN_STOP2,
  input wire logic I_INVERT_START_INPUT,
  input wire logic I_INVERT_STOP_ONE_INPUT,
  input wire logic I_INVERT_STOP_TWO_INPUT,
  input wire logic [1:0] I_BOTH_EDGE_SELECT,
  input wire logic I_CALIBRATE,
  input wire logic I_LONG_MEASURING_RANGE,
  input wire logic [1:0] I_REFERENCE_DIVIDE_SELECT,
  input wire logic [2:0] I_HITS_EXPECTED_CH1,
  input wire logic [2:0] I_HITS_EXPECTED_CH2,
  input wire logic [3:0] I_OPERAND_A_SEL,
  input wire logic [3:0] I_OPERAND_B_SEL,
  input wire logic I_ALU_GO,
  input wire logic [7:0] I_CFG1_TOP,
  input wire logic I_TEMP_OPEN,
  input wire logic I_TEMP_SHORT,
  input wire logic I_SPI_SEL_N,
  input wire logic I_SPI_SCK,
  input wire logic I_SPI_MOSI,
  output logic O_SPI_MISO,
  output logic O_ALU_BUSY,
  output logic O_RESULT_WRITE
);
  import tdc_pkg::*;

  meas_state_t st_q;
  logic long_r;
  logic [2:0] lvl;
  logic [2:0] lvl_q;
  logic [2:0] en;
  logic [2:0] both;
  logic [2:0] edg;
  logic ref_q;
  logic [1:0] rdiv_q;
  logic [1:0] rmask;
  logic ref_tick;
  logic [STAMP_W-1:0] timer_q;
  logic [PRE_W-1:0] pre_q;
  logic tmo_q;
  logic preo_q;
  logic calh_q;
  logic [STAMP_W-1:0] cal1_q;
  logic [STAMP_W-1:0] cal2_q;
  logic [2:0] cnt1_q;
  logic [2:0] cnt2_q;
  logic [2:0] exp1;
  logic [2:0] exp2;
  logic hits_done;
  logic [STAMP_W-1:0] stamp1_q [4];
  logic [STAMP_W-1:0] stamp2_q [4];
  logic [STAMP_W-1:0] opa;
  logic [STAMP_W-1:0] opb;
  logic [STAMP_W:0] dif;
  logic [STAMP_W-1:0] mag;
  logic [STAMP_W-1:0] grad;
  logic raw_mode;
  logic ovf;
  logic go_ok;
  logic busy_q;
  logic start_q;
  logic neg_q;
  logic wr_q;
  logic [31:0] wval_q;
  logic [DIV_NUM_W-1:0] num_q;
  logic [DIV_DEN_W-1:0] den_q;
  logic [31:0] quo32;
  logic [2:0] ptr_q;
  logic [31:0] slot_q [4];
  logic open_q;
  logic short_q;
  logic [15:0] stat;
  logic sck_q;
  logic [7:0] opc_q;
  logic [3:0] bit_q;
  logic [31:0] sh_q;
  logic miso_q;
  logic [2:0] rd_adr;
  logic [31:0] rd_data;
  logic [11:0] lat_q;

  div_if dbus ();

  div_unit u_div (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .bus(dbus.unit)
  );

  assign long_r = I_LONG_MEASURING_RANGE;

  // Edge selection; start is single-edge only
  assign lvl = {I_STOP2, I_STOP1, I_START}
      ^ {I_INVERT_STOP_TWO_INPUT, I_INVERT_STOP_ONE_INPUT, I_INVERT_START_INPUT};
  assign en = {I_EN_STOP2, I_EN_STOP1, I_EN_START};
  assign both = {I_BOTH_EDGE_SELECT, 1'b0};
  assign edg = en & (lvl ^ lvl_q) & (both | lvl);

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      // Seeded with the pin level so release gives no false start
      lvl_q <= lvl;
    end else begin
      lvl_q <= lvl;
    end
  end

  // Internal reference tick: external reference divided by 1, 2 or 4
  always_comb begin
    case (I_REFERENCE_DIVIDE_SELECT)
      2'h0: rmask = 2'h0;
      2'h1: rmask = 2'h1;
      default: rmask = 2'h3;
    endcase
  end
  assign ref_tick = I_REF_CLK & ~ref_q & ((rdiv_q & rmask) == rmask);

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      ref_q <= 1'b0;
      rdiv_q <= 2'h0;
    end else begin
      ref_q <= I_REF_CLK;
      if (I_REF_CLK && !ref_q) begin
        rdiv_q <= rdiv_q + 2'h1;
      end
    end
  end

  assign exp1 = (I_HITS_EXPECTED_CH1 > MAX_HITS) ? MAX_HITS : I_HITS_EXPECTED_CH1;
  assign exp2 = (I_HITS_EXPECTED_CH2 > MAX_HITS) ? MAX_HITS : I_HITS_EXPECTED_CH2;
  assign hits_done = (cnt1_q >= exp1) && (cnt2_q >= exp2);

  // Measurement sequence; the timer doubles as the calibration counter
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || I_INIT) begin
      st_q <= ST_ARMED;
      timer_q <= '0;
      pre_q <= '0;
      tmo_q <= 1'b0;
      preo_q <= 1'b0;
      calh_q <= 1'b0;
      cal1_q <= '0;
      cal2_q <= '0;
    end else begin
      case (st_q)
        ST_ARMED: begin
          if (edg[0]) begin
            st_q <= ST_RUN;
            timer_q <= STAMP_W'(1);
            pre_q <= '0;
          end
        end
        ST_RUN: begin
          timer_q <= timer_q + 1'b1;
          if (ref_tick) begin
            pre_q <= pre_q + 1'b1;
          end
          if (hits_done) begin
            st_q <= (I_CALIBRATE || long_r) ? ST_CSYNC : ST_DONE;
          end else if (!long_r && timer_q >= TIMEOUT_CYC) begin
            tmo_q <= 1'b1;
            st_q <= ST_DONE;
          end else if (long_r && ref_tick && (&pre_q)) begin
            preo_q <= 1'b1;
            st_q <= ST_DONE;
          end
        end
        ST_CSYNC: begin
          if (ref_tick) begin
            timer_q <= STAMP_W'(1);
            calh_q <= 1'b0;
            st_q <= ST_CAL;
          end
        end
        ST_CAL: begin
          timer_q <= timer_q + 1'b1;
          if (ref_tick) begin
            if (!calh_q) begin
              cal1_q <= timer_q;
              calh_q <= 1'b1;
            end else begin
              cal2_q <= timer_q;
              st_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          st_q <= ST_DONE;
        end
        default: begin
          st_q <= ST_ARMED;
        end
      endcase
    end
  end

  // Hit capture; surplus hits beyond the expected count are dropped
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || I_INIT) begin
      cnt1_q <= 3'h0;
      cnt2_q <= 3'h0;
    end else if (st_q == ST_RUN) begin
      if (edg[1] && cnt1_q < exp1) begin
        stamp1_q[cnt1_q[1:0]] <= timer_q;
        cnt1_q <= cnt1_q + 3'h1;
      end
      if (edg[2] && cnt2_q < exp2) begin
        stamp2_q[cnt2_q[1:0]] <= timer_q;
        cnt2_q <= cnt2_q + 3'h1;
      end
    end
  end

  function automatic logic [STAMP_W-1:0] pick(input logic [3:0] s);
    logic [STAMP_W-1:0] v;
    v = '0;
    if (s == SEL_CAL1) begin
      v = cal1_q;
    end else if (s == SEL_CAL2) begin
      v = cal2_q;
    end else if (s >= SEL_CH1_FIRST && s <= SEL_CH1_LAST) begin
      v = stamp1_q[2'(s - SEL_CH1_FIRST)];
    end else if (s >= SEL_CH2_FIRST && s <= SEL_CH2_LAST) begin
      v = stamp2_q[2'(s - SEL_CH2_FIRST)];
    end
    return v;
  endfunction : pick

  always_comb begin
    opa = pick(I_OPERAND_A_SEL);
    opb = pick(I_OPERAND_B_SEL);
    dif = {1'b0, opa} - {1'b0, opb};
    mag = dif[STAMP_W] ? STAMP_W'(-dif) : dif[STAMP_W-1:0];
    grad = cal2_q - cal1_q;
    raw_mode = !long_r && (!I_CALIBRATE
        || I_OPERAND_A_SEL == SEL_CAL1 || I_OPERAND_A_SEL == SEL_CAL2
        || I_OPERAND_B_SEL == SEL_CAL1 || I_OPERAND_B_SEL == SEL_CAL2);
    ovf = !long_r && ({1'b0, mag} > {grad, 1'b0});
  end

  assign go_ok = I_ALU_GO && st_q == ST_DONE && !busy_q
      && I_OPERAND_A_SEL != SEL_NOP && I_OPERAND_B_SEL != SEL_NOP;
  assign quo32 = neg_q ? 32'(-dbus.quo[31:0]) : dbus.quo[31:0];

  // One calculation at a time; a request while busy is dropped
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || I_INIT) begin
      busy_q <= 1'b0;
      start_q <= 1'b0;
      neg_q <= 1'b0;
      wr_q <= 1'b0;
      wval_q <= SLOT_RST;
      num_q <= '0;
      den_q <= '0;
    end else begin
      wr_q <= 1'b0;
      start_q <= 1'b0;
      if (go_ok) begin
        if (raw_mode) begin
          wr_q <= 1'b1;
          wval_q <= {dif[FRAC_W-1:0], 16'h0};
        end else if (ovf) begin
          wr_q <= 1'b1;
          wval_q <= ERR_VAL;
        end else begin
          start_q <= 1'b1;
          busy_q <= 1'b1;
          neg_q <= !long_r && dif[STAMP_W];
          num_q <= {mag, 16'h0};
          den_q <= grad;
        end
      end else if (busy_q && dbus.done) begin
        busy_q <= 1'b0;
        wr_q <= 1'b1;
        wval_q <= (|dbus.quo[DIV_NUM_W-1:32]) ? ERR_VAL : quo32;
      end
    end
  end

  assign dbus.start = start_q;
  assign dbus.num = num_q;
  assign dbus.den = den_q;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || I_INIT) begin
      ptr_q <= PTR_RST;
    end else if (wr_q && ptr_q < NUM_SLOTS) begin
      ptr_q <= ptr_q + 3'h1;
    end
  end

  // Slots survive init so results can still be read after rearming
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      for (int i = 0; i < 4; i++) begin
        slot_q[i] <= SLOT_RST;
      end
    end else if (wr_q && ptr_q < NUM_SLOTS && !I_INIT) begin
      slot_q[ptr_q[1:0]] <= wval_q;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      open_q <= 1'b0;
      short_q <= 1'b0;
    end else begin
      open_q <= I_TEMP_OPEN;
      short_q <= I_TEMP_SHORT;
    end
  end

  always_comb begin
    stat = 16'h0;
    stat[STAT_PTR_LSB +: 3] = ptr_q;
    stat[STAT_HIT1_LSB +: 3] = cnt1_q;
    stat[STAT_HIT2_LSB +: 3] = cnt2_q;
    stat[STAT_TMO_BIT] = tmo_q;
    stat[STAT_PRE_BIT] = preo_q;
    stat[STAT_OPEN_BIT] = open_q;
    stat[STAT_SHORT_BIT] = short_q;
  end

  // Read data left aligned so every register shifts out from the top
  assign rd_adr = {opc_q[1:0], I_SPI_MOSI};
  always_comb begin
    if (rd_adr <= ADR_RES_LAST) begin
      rd_data = slot_q[rd_adr[1:0]];
    end else if (rd_adr == ADR_STAT) begin
      rd_data = {stat, 16'h0};
    end else if (rd_adr == ADR_ECHO) begin
      rd_data = {I_CFG1_TOP, 24'h0};
    end else begin
      rd_data = 32'h0;
    end
  end

  // Serial port: sample on falling SCK, drive on rising SCK
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      sck_q <= 1'b0;
      opc_q <= 8'h0;
      bit_q <= 4'h0;
      sh_q <= 32'h0;
      miso_q <= 1'b0;
    end else begin
      sck_q <= I_SPI_SCK;
      if (I_SPI_SEL_N) begin
        bit_q <= 4'h0;
        sh_q <= 32'h0;
        miso_q <= 1'b0;
      end else if (!I_SPI_SCK && sck_q && bit_q < OPC_BITS) begin
        opc_q <= {opc_q[6:0], I_SPI_MOSI};
        bit_q <= bit_q + 4'h1;
        if (bit_q == OPC_BITS - 4'h1 && opc_q[6:2] == OPC_READ) begin
          sh_q <= rd_data;
        end
      end else if (I_SPI_SCK && !sck_q && bit_q == OPC_BITS) begin
        miso_q <= sh_q[31];
        sh_q <= {sh_q[30:0], 1'b0};
      end
    end
  end

  assign O_SPI_MISO = miso_q;
  assign O_ALU_BUSY = busy_q;
  assign O_RESULT_WRITE = wr_q;

  // Cycles since a calculation was taken, for the latency check
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || go_ok) begin
      lat_q <= 12'h0;
    end else if (busy_q) begin
      lat_q <= lat_q + 12'h1;
    end
  end

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST || I_INIT);

  sequence s_go_raw;
    go_ok && raw_mode;
  endsequence
  sequence s_go_ovf;
    go_ok && !raw_mode && ovf;
  endsequence

  property p_ptr_adv;
    wr_q && ptr_q < NUM_SLOTS |=> ptr_q == $past(ptr_q) + 3'h1;
  endproperty
  a_ptr_adv: assert property (p_ptr_adv) else $error("pointer did not advance");

  property p_slot_fill;
    wr_q && ptr_q < NUM_SLOTS |=> slot_q[$past(ptr_q[1:0])] == $past(wval_q);
  endproperty
  a_slot_fill: assert property (p_slot_fill) else $error("slot not written");

  property p_ovf;
    s_go_ovf |=> wr_q && wval_q == ERR_VAL;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow value missing");

  property p_raw_fmt;
    s_go_raw |=> wr_q && wval_q[15:0] == 16'h0 && wval_q[31:16] == $past(dif[15:0]);
  endproperty
  a_raw_fmt: assert property (p_raw_fmt) else $error("raw result format wrong");

  property p_cal_lat;
    busy_q |-> lat_q < 12'(VALID_CAL_CYC);
  endproperty
  a_cal_lat: assert property (p_cal_lat) else $error("calibrated result late");

  property p_tmo;
    st_q == ST_RUN && !long_r && !hits_done && timer_q >= TIMEOUT_CYC
      |=> tmo_q && st_q == ST_DONE;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout not taken");

  property p_gate;
    !I_EN_STOP1 |=> cnt1_q == $past(cnt1_q);
  endproperty
  a_gate: assert property (p_gate) else $error("disabled stop counted");

  property p_long_sign;
    long_r && go_ok |=> !neg_q;
  endproperty
  a_long_sign: assert property (p_long_sign) else $error("long range went negative");

  property p_cal_order;
    st_q == ST_CAL && ref_tick && calh_q |=> st_q == ST_DONE && cal2_q > cal1_q;
  endproperty
  a_cal_order: assert property (p_cal_order) else $error("calibration pair wrong");

  property p_miso_msb;
    !I_SPI_SEL_N && I_SPI_SCK && !sck_q && bit_q == OPC_BITS |=> miso_q == $past(sh_q[31]);
  endproperty
  a_miso_msb: assert property (p_miso_msb) else $error("serial order wrong");
endmodule : tdc_readout
`default_nettype wire

// ---- verif/spi_host_model.sv ----
// Host side of the serial read link, as a behavioural model.
// Assumes the bank samples the data-in line on falling clock edges.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic i_clk,
  input wire logic i_miso,
  output logic o_sel_n,
  output logic o_sck,
  output logic o_mosi
);
  initial begin
    o_sel_n = 1'b1;
    o_sck = 1'b0;
    o_mosi = 1'b0;
  end
  // Four clocks per phase, above the two-clock minimum
  task automatic half;
    repeat (4) @(posedge i_clk);
  endtask : half
  task automatic xfer(input logic [7:0] op, output logic [31:0] data);
    data = 32'h0;
    o_sel_n <= 1'b0;
    half();
    for (int i = 7; i >= 0; i--) begin
      o_mosi <= op[i];
      o_sck <= 1'b1;
      half();
      o_sck <= 1'b0;
      half();
    end
    for (int i = 0; i < 32; i++) begin
      o_sck <= 1'b1;
      half();
      data = {data[30:0], i_miso};
      o_sck <= 1'b0;
      // No pull on the line: keep it moving
      o_mosi <= ~o_mosi;
      half();
    end
    o_sel_n <= 1'b1;
    half();
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ---- verif/tdc_result_and_status_readout_bench.sv ----
// Self-checking bench of the readout bank, host model on the serial link.
// Assumes 250 MHz system clock; reference clock made here, period 40 cycles.
`timescale 1ns/1ps
`default_nettype none
module tdc_result_and_status_readout_bench;
  import tdc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic init = 1'b0;
  logic refc = 1'b0;
  logic st = 1'b0, s1 = 1'b0, s2 = 1'b0, en2 = 1'b1, cal = 1'b0, go = 1'b0;
  logic t_open = 1'b0, t_short = 1'b0;
  logic en1 = 1'b1, inv_st = 1'b1, lng = 1'b0;
  logic [1:0] bes = 2'h1;
  logic [2:0] he1 = 3'h2, he2 = 3'h1;
  logic [7:0] cfg = 8'ha5;
  logic [3:0] sa = 4'h1, sb = 4'h0;
  logic sel_n, sck, mosi, miso, busy, wr;
  logic [31:0] rd;
  int n_fail = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  always begin
    repeat (20) @(posedge clk);
    refc <= ~refc;
  end
  tdc_readout u_tdc_readout (.I_CLK_SYS(clk), .I_RST(rst), .I_INIT(init), .I_REF_CLK(refc),
    .I_START(st), .I_STOP1(s1), .I_STOP2(s2), .I_EN_START(1'b1), .I_EN_STOP1(en1),
    .I_EN_STOP2(en2), .I_INVERT_START_INPUT(inv_st), .I_INVERT_STOP_ONE_INPUT(1'b0),
    .I_INVERT_STOP_TWO_INPUT(1'b0), .I_BOTH_EDGE_SELECT(bes), .I_CALIBRATE(cal),
    .I_LONG_MEASURING_RANGE(lng), .I_REFERENCE_DIVIDE_SELECT(2'h1),
    .I_HITS_EXPECTED_CH1(he1), .I_HITS_EXPECTED_CH2(he2), .I_OPERAND_A_SEL(sa),
    .I_OPERAND_B_SEL(sb), .I_ALU_GO(go), .I_CFG1_TOP(cfg), .I_TEMP_OPEN(t_open),
    .I_TEMP_SHORT(t_short), .I_SPI_SEL_N(sel_n), .I_SPI_SCK(sck), .I_SPI_MOSI(mosi),
    .O_SPI_MISO(miso), .O_ALU_BUSY(busy), .O_RESULT_WRITE(wr));
  spi_host_model u_spi_host_model (.i_clk(clk), .i_miso(miso), .o_sel_n(sel_n), .o_sck(sck),
    .o_mosi(mosi));
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic rdreg(input logic [2:0] adr);
    u_spi_host_model.xfer({OPC_READ, adr}, rd);
  endtask : rdreg
  // Start pin raised before init: inverted start ignores the rise
  task automatic arm;
    st <= 1'b1;
    s1 <= 1'b0;
    s2 <= 1'b0;
    @(posedge clk);
    init <= 1'b1;
    @(posedge clk);
    init <= 1'b0;
    repeat (2) @(posedge clk);
    st <= 1'b0;
  endtask : arm
  task automatic alu(input logic [3:0] a, input logic [3:0] b, input logic div);
    int k;
    logic bsy;
    bsy = 1'b0;
    sa <= a;
    sb <= b;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 100 && wr !== 1'b1; k++) begin
      @(posedge clk);
      bsy = bsy | (busy === 1'b1);
    end
    if (k == 100) begin
      n_fail++;
      finish_test();
    end
    check("busy", {31'h0, bsy}, {31'h0, div});
    repeat (2) @(posedge clk);
  endtask : alu
  task automatic check_slots(input logic [31:0] e0, e1, e2);
    rdreg(3'h0);
    check("slot0", rd, e0);
    rdreg(3'h1);
    check("slot1", rd, e1);
    rdreg(3'h2);
    check("slot2", rd, e2);
    rdreg(ADR_STAT);
    check("status", {16'h0, rd[31:16]}, 32'h0053);
  endtask : check_slots
  task automatic t_reset;
    rdreg(ADR_STAT);
    check("status", {16'h0, rd[31:16]}, 32'h0);
    rdreg(ADR_ECHO);
    check("echo", {24'h0, rd[31:24]}, 32'ha5);
    rdreg(3'h6);
    check("unmapped", rd, 32'h0);
  endtask : t_reset
  task automatic t_raw;
    en2 <= 1'b0;
    arm();
    repeat (5) @(posedge clk);
    s1 <= 1'b1;
    s2 <= 1'b1;
    repeat (2) @(posedge clk);
    s2 <= 1'b0;
    repeat (2) @(posedge clk);
    s1 <= 1'b0;
    en2 <= 1'b1;
    repeat (3) @(posedge clk);
    s2 <= 1'b1;
    repeat (2) @(posedge clk);
    // Extra hit past the expected count
    s1 <= 1'b1;
    repeat (4) @(posedge clk);
    alu(4'h1, 4'h0, 1'b0);
    alu(4'h0, 4'h2, 1'b0);
    alu(4'h9, 4'h1, 1'b0);
    check_slots(32'h00050000, 32'hfff70000, 32'h00070000);
    u_spi_host_model.xfer(8'h80, rd);
    rdreg(3'h0);
    check("slot0", rd, 32'h00050000);
  endtask : t_raw
  task automatic t_timeout;
    t_open <= 1'b1;
    t_short <= 1'b1;
    en1 <= 1'b0;
    arm();
    repeat (10) @(posedge clk);
    // Stop 1 edge while its enable is low must not count
    s1 <= 1'b1;
    repeat (460) @(posedge clk);
    rdreg(ADR_STAT);
    check("status", {16'h0, rd[31:16]}, 32'h1a00);
    t_open <= 1'b0;
    t_short <= 1'b0;
    en1 <= 1'b1;
  endtask : t_timeout
  // Internal tick every 80 cycles: overflow above 160
  task automatic t_cal;
    cal <= 1'b1;
    arm();
    repeat (20) @(posedge clk);
    s1 <= 1'b1;
    repeat (10) @(posedge clk);
    s2 <= 1'b1;
    repeat (140) @(posedge clk);
    s1 <= 1'b0;
    repeat (300) @(posedge clk);
    alu(4'h1, 4'h0, 1'b1);
    alu(4'h2, 4'h0, 1'b0);
    alu(4'h7, 4'h6, 1'b0);
    check_slots(32'h00004000, 32'hffffffff, 32'h00500000);
  endtask : t_cal
  // Long range calibrates even with calibrate off; sign dropped
  task automatic t_long;
    cal <= 1'b0;
    lng <= 1'b1;
    arm();
    repeat (20) @(posedge clk);
    s1 <= 1'b1;
    s2 <= 1'b1;
    repeat (10) @(posedge clk);
    s1 <= 1'b0;
    repeat (300) @(posedge clk);
    alu(4'h0, 4'h1, 1'b1);
    alu(4'h7, 4'h6, 1'b1);
    rdreg(3'h0);
    check("long0", rd, 32'h00004000);
    rdreg(3'h1);
    check("long1", rd, 32'h00010000);
    lng <= 1'b0;
  endtask : t_long
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_raw();
    t_timeout();
    t_cal();
    t_long();
    finish_test();
  end
endmodule : tdc_result_and_status_readout_bench
`default_nettype wire
